// *** bench/tb_twe_top.sv ***
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/10ps

module tb_twe_top;
  localparam int DENS = 2;
  localparam int WCC  = 400;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        clk_en = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  pins = 3'h5;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, scl, sda_o, sda_oe_n, sda_drv, sda_line, er;
  int          err_total = 0;
  int          comparisons = 0;

  // Open drain with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_o);
  always #4 pclk = ~pclk;

  twe_top #(.DENSITY(DENS), .WRITE_CYCLE_CLKS(WCC)) i_twe_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .hardwired_select_pin_2(pins[2]), .hardwired_select_pin_1(pins[1]),
    .hardwired_select_pin_0(pins[0]));
  twe_ctl i_twe_ctl (.pclk(pclk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));

  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic x);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    x = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic x);
    apb(1'h0, a, 32'h0, rd, er);
    chk("prdata", rd, e);
    chk("pslverr", {31'h0, er}, {31'h0, x});
  endtask

  function automatic logic [7:0] dw(input logic p, rw);
    return {twe_pkg::DEV_TYPE, pins[2:1], p, rw};
  endfunction

  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    i_twe_ctl.byte_w(d, a);
    chk("ack", {31'h0, a}, {31'h0, e});
  endtask

  task automatic rb(input logic a, input logic [7:0] e);
    logic [7:0] d;
    i_twe_ctl.byte_r(a, d);
    chk("read", {24'h0, d}, {24'h0, e});
  endtask

  task automatic poll(input logic e);
    i_twe_ctl.start();
    wb(dw(1'h1, 1'h0), e);
    i_twe_ctl.stop();
  endtask

  task automatic t_regs();
    rchk(twe_pkg::OFS_CTRL, 32'h1, 1'h0);
    rchk(twe_pkg::OFS_STATUS, 32'h1, 1'h0);
    rchk(twe_pkg::OFS_ADDR, 32'h0, 1'h0);
    rchk(8'h0C, 32'h0, 1'h1);
    apb(1'h1, twe_pkg::OFS_STATUS, 32'h6, rd, er);
    rchk(twe_pkg::OFS_STATUS, 32'h1, 1'h0);
    // Disabled target must ignore the bus entirely
    apb(1'h1, twe_pkg::OFS_CTRL, 32'h0, rd, er);
    rchk(twe_pkg::OFS_CTRL, 32'h0, 1'h0);
    poll(1'h0);
    apb(1'h1, twe_pkg::OFS_CTRL, 32'h1, rd, er);
    rchk(twe_pkg::OFS_CTRL, 32'h1, 1'h0);
  endtask

  // Seventeen bytes into a 16-byte page: first slot overwritten
  task automatic t_page();
    i_twe_ctl.start();
    wb(dw(1'h1, 1'h0), 1'h1);
    wb(8'hF0, 1'h1);
    for (int i = 0; i < 17; i++) wb(8'(i), 1'h1);
    i_twe_ctl.stop();
    rchk(twe_pkg::OFS_STATUS, 32'h2, 1'h0);
    poll(1'h0);
    rchk(twe_pkg::OFS_ADDR, 32'h1F1, 1'h0);
    repeat (WCC) @(posedge pclk);
    poll(1'h1);
  endtask

  task automatic t_byte();
    i_twe_ctl.start();
    wb(dw(1'h0, 1'h0), 1'h1);
    wb(8'h00, 1'h1);
    wb(8'h5A, 1'h1);
    i_twe_ctl.stop();
    repeat (WCC + 8) @(posedge pclk);
    rchk(twe_pkg::OFS_STATUS, 32'h1, 1'h0);
  endtask

  task automatic t_read();
    i_twe_ctl.start();
    wb(dw(1'h1, 1'h0), 1'h1);
    wb(8'hFE, 1'h1);
    i_twe_ctl.start();
    wb(dw(1'h1, 1'h1), 1'h1);
    rb(1'h1, 8'h0E);
    rb(1'h0, 8'h0F);
    i_twe_ctl.stop();
    rchk(twe_pkg::OFS_STATUS, 32'h1, 1'h0);
    i_twe_ctl.start();
    wb(dw(1'h0, 1'h1), 1'h1);
    rb(1'h0, 8'h5A);
    i_twe_ctl.stop();
    rchk(twe_pkg::OFS_ADDR, 32'h1, 1'h0);
  endtask

  task automatic t_neg();
    i_twe_ctl.start();
    wb({twe_pkg::DEV_TYPE, ~pins[2:1], 2'h0}, 1'h0);
    i_twe_ctl.stop();
    rchk(twe_pkg::OFS_STATUS, 32'h1, 1'h0);
    pins <= 3'h3;
    clk_en <= 1'h0;
    poll(1'h0);
    clk_en <= 1'h1;
    poll(1'h1);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_page();
    t_byte();
    t_read();
    t_neg();
    tally_and_finish();
  end

  // Whole run is near 7800 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
endmodule // tb_twe_top

bind twe_top twe_top_asserts i_twe_top_asserts (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .scl(scl), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// *** bench/twe_ctl.sv ***
// Behavioural two-wire bus controller facing the target
`timescale 1ns/10ps

module twe_ctl (
  // Clock
  input  logic pclk,
  // Two-wire bus
  input  logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Bus idles released; scl stands high between frames
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic start();
    sda_drv <= 1'h1;
    hw(5);
    scl <= 1'h1;
    hw(10);
    sda_drv <= 1'h0;
    hw(10);
    scl <= 1'h0;
    hw(5);
  endtask

  task automatic stop();
    sda_drv <= 1'h0;
    hw(5);
    scl <= 1'h1;
    hw(10);
    sda_drv <= 1'h1;
    hw(10);
  endtask

  // Data moves mid-low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_drv <= b;
    hw(5);
    scl <= 1'h1;
    hw(5);
    r = sda_line;
    hw(5);
    scl <= 1'h0;
    hw(5);
  endtask

  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, r);
    ack = !r;
  endtask

  task automatic byte_r(input logic ack_me, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
    bit_x(!ack_me, r);
  endtask
endmodule // twe_ctl

// *** bench/twe_top_asserts.sv ***
// Port-level assertions for the two-wire EEPROM target
`timescale 1ns/10ps

module twe_top_asserts (
  // Clock, reset, enable
  input logic        pclk,
  input logic        presetn,
  input logic        clk_en,
  // APB
  input logic        psel,
  input logic        penable,
  input logic [7:0]  paddr,
  input logic        pready,
  input logic        pslverr,
  // Two-wire bus
  input logic        scl,
  input logic        sda_o,
  input logic        sda_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rst_rel;
    $rose(presetn) |-> sda_oe_n && !pready;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("bus or apb busy after reset");

  property p_od;
    sda_o == 1'h0;
  endproperty
  a_od: assert property (p_od)
    else $error("sda driven high");

  property p_chg_low;
    $changed(sda_oe_n) |-> !scl;
  endproperty
  a_chg_low: assert property (p_chg_low)
    else $error("sda changed while scl high");

  property p_ack_hold;
    $fell(sda_oe_n) |=> !sda_oe_n [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("low level on sda too short");

  property p_apb_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not in second access cycle");

  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready longer than one cycle");

  property p_err;
    pready |-> pslverr == !(paddr == twe_pkg::OFS_CTRL ||
                            paddr == twe_pkg::OFS_STATUS ||
                            paddr == twe_pkg::OFS_ADDR);
  endproperty
  a_err: assert property (p_err)
    else $error("pslverr wrong for address");

  property p_frz;
    !clk_en |=> $stable(sda_oe_n);
  endproperty
  a_frz: assert property (p_frz)
    else $error("sda moved while disabled");

  c_ack: cover property ($fell(sda_oe_n));
  c_err: cover property (pslverr);
  c_frz: cover property (!clk_en);
endmodule // twe_top_asserts

// *** rtl/twe_pkg.sv ***
// Constants, timing and density helpers for the two-wire EEPROM target
package twe_pkg;

  // ****************************************
  // Protocol
  // ****************************************
  localparam logic [3:0] DEV_TYPE       = 4'hA;
  localparam int         BYTE_BITS      = 8;
  localparam int         MIN_AW         = 7;
  localparam int         SMALL_PAGE_LOG = 3;
  localparam int         LARGE_PAGE_LOG = 4;
  localparam int         SMALL_DENS     = 2;
  localparam int         DENS_16K       = 4;
  localparam int         NSEL           = 3;
  localparam int         EXT_AW         = NSEL + BYTE_BITS;

  localparam logic [1:0] KIND_DEV   = 2'h0;
  localparam logic [1:0] KIND_WADDR = 2'h1;
  localparam logic [1:0] KIND_DATA  = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int WR_TIME_MS = 10;
  localparam int CLK_MHZ    = 125;
  localparam int US_PER_MS  = 1000;
  localparam int WR_CYCLES  = WR_TIME_MS * US_PER_MS * CLK_MHZ;
  localparam int TIMER_W    = 21;

  // ****************************************
  // Register map
  // ****************************************
  localparam int         APB_AW      = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ADDR    = 8'h08;
  localparam int         CTRL_EN     = 0;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam int         ST_STANDBY  = 0;
  localparam int         ST_BUSY     = 1;
  localparam int         ST_ACTIVE   = 2;

  // ****************************************
  // Density helpers (0 smallest .. 4 largest)
  // ****************************************
  function automatic int addr_w(input int d);
    return MIN_AW + d;
  endfunction

  function automatic int page_bits(input int d);
    return (d < SMALL_DENS) ? 0 : d - 1;
  endfunction

  function automatic int page_log(input int d);
    return (d < SMALL_DENS) ? SMALL_PAGE_LOG : LARGE_PAGE_LOG;
  endfunction

endpackage

// *** rtl/twe_top.sv ***
// Two-wire serial EEPROM target: protocol engine, memory and APB status
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps

module twe_top #(
  parameter int DENSITY          = twe_pkg::DENS_16K,
  parameter int WRITE_CYCLE_CLKS = twe_pkg::WR_CYCLES
) (
  // Clock, reset, enable
  input  logic        pclk,
  input  logic        presetn,
  input  logic        clk_en,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Two-wire bus
  input  logic        scl,
  input  logic        sda_i,
  output logic        sda_o,
  output logic        sda_oe_n,
  // Strap pins
  input  logic        hardwired_select_pin_2,
  input  logic        hardwired_select_pin_1,
  input  logic        hardwired_select_pin_0
);

  // ****************************************
  // Density derived sizes
  // ****************************************
  localparam int AW    = twe_pkg::addr_w(DENSITY);
  localparam int PB    = twe_pkg::page_bits(DENSITY);
  localparam int PL    = twe_pkg::page_log(DENSITY);
  localparam int DEPTH = 1 << AW;
  localparam int TW    = twe_pkg::TIMER_W;
  localparam int NS    = twe_pkg::NSEL;
  localparam int BB    = twe_pkg::BYTE_BITS;

  localparam logic [AW-1:0] PMASK    = AW'((1 << PL) - 1);
  localparam logic [AW-1:0] AONE     = AW'(1);
  localparam logic [NS-1:0] SEL_MASK = NS'((1 << PB) - 1);
  localparam logic [TW-1:0] TONE     = TW'(1);
  localparam logic [TW-1:0] TLOAD    = TW'(WRITE_CYCLE_CLKS);
  localparam logic [3:0]    CNT_FULL = 4'(BB);
  localparam logic [3:0]    CNT_LAST = 4'(BB - 1);
  localparam logic [3:0]    CONE     = 4'h1;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_RACK = 5'b00100,
    ST_TX   = 5'b01000,
    ST_TACK = 5'b10000
  } twe_state_e;

  typedef struct packed {
    logic          scl_m;
    logic          scl_s;
    logic          scl_p;
    logic          sda_m;
    logic          sda_s;
    logic          sda_p;
    logic [NS-1:0] pin_m;
    logic [NS-1:0] pin_s;
    twe_state_e    state;
    logic [1:0]    kind;
    logic          rw;
    logic [7:0]    sh;
    logic [3:0]    cnt;
    logic          ack;
    logic [NS-1:0] page;
    logic [AW-1:0] addr;
    logic          wrote;
    logic [TW-1:0] busy_cnt;
    logic          sda_o;
    logic          sda_oe_n;
    logic          enable;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } twe_st_s;

  twe_st_s r;
  twe_st_s n;

  // Nonvolatile array, no reset on purpose
  logic [7:0] mem [0:DEPTH-1];

  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]    mem_wd;
  logic [7:0]    rd_byte;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_c;
  logic          stop_c;
  logic          busy;
  logic          dev_hit;
  logic          acc;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Select bits below PB are page bits and are not compared
  function automatic logic sel_match(input logic [7:0]    w,
                                     input logic [NS-1:0] pins);
    logic ok;
    ok = (w[7:4] == twe_pkg::DEV_TYPE);
    for (int i = 0; i < NS; i++) begin
      if (i >= PB && w[i+1] != pins[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == twe_pkg::OFS_CTRL) || (a == twe_pkg::OFS_STATUS) ||
           (a == twe_pkg::OFS_ADDR);
  endfunction

  // Edges seen on the twice-synchronised copies only
  assign scl_rise = r.scl_s & ~r.scl_p;
  assign scl_fall = ~r.scl_s & r.scl_p;
  assign start_c  = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
  assign stop_c   = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
  assign busy     = (r.busy_cnt != '0);
  assign dev_hit  = sel_match(r.sh, r.pin_s);
  assign acc      = psel & penable;
  assign rd_byte  = mem[r.addr];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n      = r;
    mem_we = 1'b0;
    mem_wa = r.addr;
    mem_wd = r.sh;

    n.scl_m = scl;
    n.scl_s = r.scl_m;
    n.scl_p = r.scl_s;
    n.sda_m = sda_i;
    n.sda_s = r.sda_m;
    n.sda_p = r.sda_s;
    n.pin_m = {hardwired_select_pin_2, hardwired_select_pin_1,
               hardwired_select_pin_0};
    n.pin_s = r.pin_m;
    n.sda_o = 1'b0;

    if (busy) begin
      n.busy_cnt = r.busy_cnt - TONE;
    end

    // Busy or disabled: no response at all, polls go unacknowledged
    if (!r.enable || busy) begin
      n.state    = ST_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (start_c) begin
      n.state    = ST_RX;
      n.kind     = twe_pkg::KIND_DEV;
      n.cnt      = '0;
      n.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      n.state    = ST_IDLE;
      n.sda_oe_n = 1'b1;
      if (r.wrote) begin
        n.busy_cnt = TLOAD;
        n.wrote    = 1'b0;
      end
    end else begin
      unique case (r.state)
        ST_IDLE: begin
          n.sda_oe_n = 1'b1;
        end
        ST_RX: begin
          if (scl_rise) begin
            n.sh  = {r.sh[6:0], r.sda_s};
            n.cnt = r.cnt + CONE;
          end else if (scl_fall && r.cnt == CNT_FULL) begin
            n.cnt      = '0;
            n.state    = ST_RACK;
            n.sda_oe_n = 1'b0;
            unique case (r.kind)
              twe_pkg::KIND_DEV: begin
                if (dev_hit) begin
                  n.rw   = r.sh[0];
                  n.page = r.sh[NS:1] & SEL_MASK;
                end else begin
                  n.state    = ST_IDLE;
                  n.sda_oe_n = 1'b1;
                end
              end
              twe_pkg::KIND_WADDR: begin
                n.addr = AW'({r.page, r.sh});
              end
              default: begin
                mem_we  = 1'b1;
                n.wrote = 1'b1;
                n.addr  = (r.addr & ~PMASK) |
                          ((r.addr + AONE) & PMASK);
              end
            endcase
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            n.cnt = '0;
            if (r.kind == twe_pkg::KIND_DEV && r.rw) begin
              n.sh       = rd_byte;
              n.addr     = r.addr + AONE;
              n.sda_oe_n = rd_byte[7];
              n.state    = ST_TX;
            end else begin
              n.sda_oe_n = 1'b1;
              n.state    = ST_RX;
              n.kind     = (r.kind == twe_pkg::KIND_DEV) ?
                           twe_pkg::KIND_WADDR : twe_pkg::KIND_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (r.cnt == CNT_LAST) begin
              n.sda_oe_n = 1'b1;
              n.state    = ST_TACK;
            end else begin
              n.cnt      = r.cnt + CONE;
              n.sh       = {r.sh[6:0], 1'b0};
              n.sda_oe_n = r.sh[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            n.ack = ~r.sda_s;
          end else if (scl_fall) begin
            n.cnt = '0;
            if (r.ack) begin
              n.sh       = rd_byte;
              n.addr     = r.addr + AONE;
              n.sda_oe_n = rd_byte[7];
              n.state    = ST_TX;
            end else begin
              n.state = ST_IDLE;
            end
          end
        end
        default: begin
          n.state    = ST_IDLE;
          n.sda_oe_n = 1'b1;
        end
      endcase
    end

    // ****************************************
    // APB slave, one wait state
    // ****************************************
    n.pready  = acc & ~r.pready;
    n.pslverr = 1'b0;
    if (acc && !r.pready) begin
      n.pslverr = ~is_mapped(paddr);
      n.prdata  = '0;
      if (!pwrite) begin
        if (paddr == twe_pkg::OFS_CTRL) begin
          n.prdata[twe_pkg::CTRL_EN] = r.enable;
        end else if (paddr == twe_pkg::OFS_STATUS) begin
          n.prdata[twe_pkg::ST_STANDBY] =
            (r.state == ST_IDLE) & ~busy;
          n.prdata[twe_pkg::ST_BUSY]    = busy;
          n.prdata[twe_pkg::ST_ACTIVE]  = (r.state != ST_IDLE);
        end else if (paddr == twe_pkg::OFS_ADDR) begin
          n.prdata[AW-1:0] = r.addr;
        end
      end
    end
    // Write lands only at the edge where pready is seen high
    if (acc && r.pready && pwrite && paddr == twe_pkg::OFS_CTRL) begin
      n.enable = pwdata[twe_pkg::CTRL_EN];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.state    <= ST_IDLE;
      r.sda_oe_n <= 1'b1;
      r.enable   <= twe_pkg::CTRL_EN_RST;
      // Idle bus level, so no false edge after reset
      {r.scl_m, r.scl_s, r.scl_p} <= 3'h7;
      {r.sda_m, r.sda_s, r.sda_p} <= 3'h7;
    end else if (clk_en) begin
      r <= n;
    end
  end

  always_ff @(posedge pclk) begin
    if (clk_en && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign prdata   = r.prdata;
  assign pready   = r.pready;
  assign pslverr  = r.pslverr;
  assign sda_o    = r.sda_o;
  assign sda_oe_n = r.sda_oe_n;

endmodule // twe_top
